// ### logic/bcc_pkg.sv
// constants and types shared by the branch, call and clear decode core
package bcc_pkg;
    // ==========================================================
    // widths
    localparam int PC_W     = 21;
    localparam int DADDR_W  = 12;
    localparam int BANK_W   = 4;
    localparam int STATUS_W = 5;

    // ==========================================================
    // q phases (gray order) and sequencer states
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } bcc_phase_t;

    typedef enum logic {
        ST_EXEC  = 1'b0,
        ST_FLUSH = 1'b1
    } bcc_state_t;

    // ==========================================================
    // opcode patterns
    localparam logic [7:0]  OP_BR_OVF   = 8'he4;    // upper byte, low byte is offset
    localparam logic [7:0]  OP_BR_ZERO  = 8'he0;
    localparam logic [6:0]  OP_CALL     = 7'h76;    // 1110 110s
    localparam logic [6:0]  OP_CLR_REG  = 7'h35;    // 0110 101a
    localparam logic [15:0] OP_CLR_WDOG = 16'h0004;
    localparam logic [5:0]  OP_CPL_REG  = 6'h07;    // 0001 11da
    localparam logic [3:0]  CALL2_NIB = 4'hf;     // second call word prefix

    // ==========================================================
    // instruction field positions
    localparam int FAST_BIT = 8;
    localparam int ASEL_BIT = 8;
    localparam int DEST_BIT = 9;

    // ==========================================================
    // status bit positions
    localparam int SB_C  = 0;
    localparam int SB_DC = 1;
    localparam int SB_Z  = 2;
    localparam int SB_OV = 3;
    localparam int SB_N  = 4;

    // ==========================================================
    // addressing and reset values
    localparam logic [7:0]          ACC_SPLIT   = 8'h5f;
    localparam logic [BANK_W-1:0]   ACC_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0]   ACC_HI_BANK = 4'hf;
    localparam logic [PC_W-1:0]     PC_STEP     = 21'h000002;
    localparam logic [PC_W-1:0]     PC_RST      = 21'h000000;
    localparam logic [STATUS_W-1:0] STATUS_RST  = 5'h00;
    localparam logic [7:0]          BYTE_ZERO   = 8'h00;
endpackage : bcc_pkg

// ### logic/bcc_addr_resolve.sv
// data memory address resolution for byte-oriented register instructions
module bcc_addr_resolve
    import bcc_pkg::*;
(
    // instruction fields
    input  wire logic               access_sel,
    input  wire logic [7:0]         file_addr,
    // addressing context
    input  wire logic [BANK_W-1:0]  bank_sel,
    input  wire logic               ext_iset_en,
    input  wire logic [DADDR_W-1:0] index_base,
    // result
    output wire logic [DADDR_W-1:0] phys_addr
);
    // ==========================================================
    // mode selection
    wire logic                low_half  = (file_addr <= ACC_SPLIT);
    wire logic                indexed   = !access_sel && ext_iset_en && low_half;  // RULE_11
    wire logic [BANK_W-1:0]   acc_bank  = low_half ? ACC_LO_BANK : ACC_HI_BANK;
    wire logic [DADDR_W-1:0]  idx_addr  = index_base + {{(DADDR_W-8){1'b0}}, file_addr};
    wire logic [DADDR_W-1:0]  bank_addr = {access_sel ? bank_sel : acc_bank, file_addr}; // RULE_10

    assign phys_addr = indexed ? idx_addr : bank_addr;
endmodule : bcc_addr_resolve

// ### logic/bcc_core.sv
// execute core for conditional branches, call, clear, watchdog clear and complement
// Functional notes
// (RULE_01) Branch on overflow is taken only when the overflow flag is 1, else fall through.
// (RULE_02) Branch on zero is taken only when the zero flag is 1, with an 8-bit offset.
// (RULE_03) A taken branch adds twice the signed offset to the already incremented counter.
// (RULE_04) A branch takes one cycle untaken and two when taken, the second a flush no-op.
// (RULE_05) A call pushes the address after its two words, current address plus 4.
// (RULE_06) With the fast-save bit set a call copies accumulator, status and bank pointer to shadows.
// (RULE_07) A call loads its 20-bit literal into counter bits 20:1 and takes two cycles.
// (RULE_08) The first call word carries literal bits 7:0, the second is all-ones prefixed bits 19:8.
// (RULE_09) Clear writes zero to the register and sets only the zero flag in one cycle.
// (RULE_10) Access-select 0 picks the access bank, 1 picks the bank named by the bank pointer.
// (RULE_11) Access-select 0 with extended set on and address at most 5Fh uses indexed offset mode.
// (RULE_12) Watchdog clear resets counter and postscaler and sets both active-low status bits.
// (RULE_13) Complement inverts the register into the accumulator or back, updating N and Z.
// (RULE_14) Register instructions run decode, read, process and write over the four phases.
// (RULE_15) Branches test the status as left by earlier instructions and change no flag.
module bcc_core
    import bcc_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // program memory
    output logic      [PC_W-1:0]     prog_addr,
    input  wire logic [15:0]         prog_data,
    // data memory, asynchronous read
    output logic      [DADDR_W-1:0]  data_addr,
    output logic      [7:0]          data_wdata,
    output logic                     data_we,
    input  wire logic [7:0]          data_rdata,
    // addressing context
    input  wire logic                ext_iset_en,
    input  wire logic [DADDR_W-1:0]  index_base,
    input  wire logic [BANK_W-1:0]   bank_select_ptr,
    // flag updates by other instructions
    input  wire logic                alu_flag_we,
    input  wire logic [STATUS_W-1:0] alu_flags,
    // watchdog
    input  wire logic                wdt_expired,
    input  wire logic                sleep_entered,
    output logic                     wdt_clear,
    output logic                     watchdog_expiry_flag_n,
    output logic                     sleep_flag_n,
    // core state
    output logic      [7:0]          accumulator,
    output logic      [STATUS_W-1:0] status,
    output logic      [7:0]          accumulator_shadow,
    output logic      [STATUS_W-1:0] flags_shadow,
    output logic      [BANK_W-1:0]   bank_select_shadow,
    output logic      [PC_W-1:0]     return_stack_top,
    output logic                     stack_push
);
    // ==========================================================
    // sequencer registers
    bcc_phase_t       phase;
    bcc_phase_t       next_phase;
    bcc_state_t       state;
    bcc_state_t       next_state;
    logic [15:0]      ir;
    logic [7:0]       operand;
    logic [PC_W-1:0]  next_pc;

    // phase advance in gray order
    always_comb begin
        unique case (phase)
            PH_Q1: next_phase = PH_Q2;
            PH_Q2: next_phase = PH_Q3;
            PH_Q3: next_phase = PH_Q4;
            PH_Q4: next_phase = PH_Q1;
        endcase
    end

    // ==========================================================
    // decode
    wire logic exec        = (state == ST_EXEC);
    wire logic at_q1       = (phase == PH_Q1);
    wire logic at_q2       = (phase == PH_Q2);
    wire logic at_q3       = (phase == PH_Q3);
    wire logic at_q4       = (phase == PH_Q4);
    wire logic is_br_ovf   = exec && (ir[15:8] == OP_BR_OVF);
    wire logic is_br_zero  = exec && (ir[15:8] == OP_BR_ZERO);
    wire logic is_call     = exec && (ir[15:9] == OP_CALL);
    wire logic is_clr_reg  = exec && (ir[15:9] == OP_CLR_REG);
    wire logic is_clr_wdog = exec && (ir == OP_CLR_WDOG);
    wire logic is_cpl_reg  = exec && (ir[15:10] == OP_CPL_REG);
    wire logic to_file     = is_clr_reg || (is_cpl_reg && ir[DEST_BIT]);
    wire logic to_acc      = is_cpl_reg && !ir[DEST_BIT];
    wire logic fast_save   = is_call && ir[FAST_BIT];

    // branch condition on the current status
    wire logic take_br  = (is_br_ovf && status[SB_OV])                 // RULE_01
                       || (is_br_zero && status[SB_Z]);                // RULE_02 RULE_15
    wire logic redirect = take_br || is_call;

    // targets
    wire logic [PC_W-1:0] br_target   = prog_addr + {{(PC_W-9){ir[7]}}, ir[7:0], 1'b0}; // RULE_03
    wire logic [PC_W-1:0] call_target = {prog_data[11:0], ir[7:0], 1'b0};            // RULE_07 RULE_08
    wire logic [PC_W-1:0] ret_addr    = prog_addr + PC_STEP;                          // RULE_05

    // process stage result
    wire logic [7:0] result   = is_clr_reg ? BYTE_ZERO : ~operand;                   // RULE_09 RULE_13
    wire logic [DADDR_W-1:0] phys_addr;

    // next counter and state at the end of q4
    assign next_pc    = take_br ? br_target : (is_call ? call_target : prog_addr + PC_STEP);
    assign next_state = redirect ? ST_FLUSH : ST_EXEC;                                // RULE_04 RULE_07

    // register address for byte-oriented instructions
    bcc_addr_resolve bcc_addr_resolve_i (
        .access_sel  (ir[ASEL_BIT]),
        .file_addr   (ir[7:0]),
        .bank_sel    (bank_select_ptr),
        .ext_iset_en (ext_iset_en),
        .index_base  (index_base),
        .phys_addr   (phys_addr)
    );

    // ==========================================================
    // fetch and sequencing: the prefetched word is taken at q4
    always_ff @(posedge clk) begin
        if (rst) begin
            phase     <= PH_Q1;
            state     <= ST_FLUSH;
            prog_addr <= PC_RST;
            ir        <= 16'h0000;
        end else begin
            phase <= next_phase;
            if (at_q4) begin
                state     <= next_state;
                prog_addr <= next_pc;
                ir        <= prog_data;
            end
        end
    end

    // decode at q1, read at q2, process at q3, write at q4
    always_ff @(posedge clk) begin
        if (rst) begin
            data_addr  <= {DADDR_W{1'b0}};
            operand    <= BYTE_ZERO;
            data_wdata <= BYTE_ZERO;
            data_we    <= 1'b0;
            accumulator <= BYTE_ZERO;
        end else begin
            if (at_q1)
                data_addr <= phys_addr;              // RULE_14
            if (at_q2)
                operand <= data_rdata;               // RULE_14
            if (at_q3)
                data_wdata <= result;
            data_we <= at_q3 && to_file;             // RULE_14
            if (at_q4 && to_acc)
                accumulator <= data_wdata;           // RULE_13
        end
    end

    // status flags: own updates at q3 win over the external load
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= STATUS_RST;
        end else if (at_q3 && is_clr_reg) begin
            status[SB_Z] <= 1'b1;                    // RULE_09
        end else if (at_q3 && is_cpl_reg) begin
            status[SB_N] <= result[7];               // RULE_13
            status[SB_Z] <= (result == BYTE_ZERO);   // RULE_13
        end else if (alu_flag_we) begin
            status <= alu_flags;                     // RULE_15
        end
    end

    // return stack push and fast-save shadows at q3 of a call
    always_ff @(posedge clk) begin
        if (rst) begin
            return_stack_top   <= PC_RST;
            stack_push         <= 1'b0;
            accumulator_shadow <= BYTE_ZERO;
            flags_shadow       <= STATUS_RST;
            bank_select_shadow <= ACC_LO_BANK;
        end else begin
            stack_push <= at_q3 && is_call;          // RULE_05
            if (at_q3 && is_call)
                return_stack_top <= ret_addr;        // RULE_05
            if (at_q3 && fast_save) begin
                accumulator_shadow <= accumulator;   // RULE_06
                flags_shadow       <= status;        // RULE_06
                bank_select_shadow <= bank_select_ptr;
            end
        end
    end

    // watchdog clear pulse and active-low flags; an expiry or sleep event in the
    // same clock as the clear wins, so no event is lost
    always_ff @(posedge clk) begin
        if (rst) begin
            wdt_clear              <= 1'b0;
            watchdog_expiry_flag_n <= 1'b1;
            sleep_flag_n           <= 1'b1;
        end else begin
            wdt_clear <= at_q3 && is_clr_wdog;       // RULE_12
            if (wdt_expired)
                watchdog_expiry_flag_n <= 1'b0;
            else if (at_q3 && is_clr_wdog)
                watchdog_expiry_flag_n <= 1'b1;      // RULE_12
            if (sleep_entered)
                sleep_flag_n <= 1'b0;
            else if (at_q3 && is_clr_wdog)
                sleep_flag_n <= 1'b1;                // RULE_12
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_ovf_taken: assert property (at_q4 && is_br_ovf && status[SB_OV] |=> // RULE_01
        state == ST_FLUSH && prog_addr == $past(br_target))
        else $error("overflow branch not taken");
    chk_zero_fall: assert property (at_q4 && is_br_zero && !status[SB_Z] |=> // RULE_02
        state == ST_EXEC && prog_addr == $past(prog_addr) + PC_STEP)
        else $error("zero branch wrongly taken");
    chk_br_offset: assert property (at_q4 && take_br |=> // RULE_03
        prog_addr == $past(prog_addr) + {{(PC_W-9){$past(ir[7])}}, $past(ir[7:0]), 1'b0})
        else $error("branch target offset wrong");
    chk_flush_len: assert property (at_q1 && state == ST_FLUSH |-> // RULE_04
        (state == ST_FLUSH)[*4] ##1 state == ST_EXEC)
        else $error("flush cycle length wrong");
    chk_call_push: assert property (at_q3 && is_call |=> // RULE_05
        stack_push && return_stack_top == $past(prog_addr) + PC_STEP)
        else $error("return address not pushed");
    chk_shadow_keep: assert property (at_q3 && is_call && !ir[FAST_BIT] |=> // RULE_06
        $stable(accumulator_shadow) && $stable(flags_shadow))
        else $error("shadows changed without fast save");
    chk_call_target: assert property (at_q4 && is_call |=> // RULE_07
        prog_addr == {$past(prog_data[11:0]), $past(ir[7:0]), 1'b0} && state == ST_FLUSH)
        else $error("call target wrong");
    chk_clr_write: assert property (at_q3 && is_clr_reg |=> // RULE_09
        data_we && data_wdata == BYTE_ZERO && status[SB_Z] && $stable(status[SB_OV]))
        else $error("clear did not write zero");
    chk_bank_addr: assert property (at_q2 && exec && ir[ASEL_BIT] |-> // RULE_10
        data_addr == {$past(bank_select_ptr), ir[7:0]})
        else $error("banked address wrong");
    chk_index_addr: assert property (at_q2 && exec && !ir[ASEL_BIT] && $past(ext_iset_en) // RULE_11
        && ir[7:0] <= ACC_SPLIT |-> data_addr == $past(index_base) + {4'h0, ir[7:0]})
        else $error("indexed address wrong");
    chk_wdt_flags: assert property (at_q3 && is_clr_wdog // RULE_12
        && !wdt_expired && !sleep_entered |=>
        wdt_clear && watchdog_expiry_flag_n && sleep_flag_n ##1 !wdt_clear)
        else $error("watchdog clear flags wrong");
    chk_cpl_acc: assert property (at_q3 && to_acc |=> ##1 accumulator == ~$past(operand, 2)) // RULE_13
        else $error("complement to accumulator wrong");
    chk_write_q4: assert property (data_we |-> phase == PH_Q4) // RULE_14
        else $error("write outside q4");
    chk_br_flags: assert property ((is_br_ovf || is_br_zero) && !alu_flag_we |=> // RULE_15
        $stable(status))
        else $error("branch changed status");

    cov_br_taken: cover property (at_q4 && take_br ##1 state == ST_FLUSH);
    cov_fast_call: cover property (at_q3 && fast_save);
    cov_cpl_file: cover property (at_q3 && is_cpl_reg && ir[DEST_BIT] ##1 data_we);
    cov_clear_watchdog: cover property (wdt_clear);
endmodule : bcc_core

// ### dv/bcc_core_tb_top.sv
// self-checking bench for the branch, call, clear and complement execute core
module bcc_core_tb_top
    import bcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // signals, memories and counters
    logic                clk;
    logic                rst;
    logic [PC_W-1:0]     prog_addr;
    logic [15:0]         prog_data;
    logic [DADDR_W-1:0]  data_addr;
    logic [7:0]          data_wdata;
    logic                data_we;
    logic [7:0]          data_rdata;
    logic                ext_iset_en;
    logic [DADDR_W-1:0]  index_base;
    logic [BANK_W-1:0]   bank_select_ptr;
    logic                alu_flag_we;
    logic [STATUS_W-1:0] alu_flags;
    logic                wdt_expired;
    logic                sleep_entered;
    logic                wdt_clear;
    logic                watchdog_expiry_flag_n;
    logic                sleep_flag_n;
    logic [7:0]          accumulator;
    logic [STATUS_W-1:0] status;
    logic [7:0]          accumulator_shadow;
    logic [STATUS_W-1:0] flags_shadow;
    logic [BANK_W-1:0]   bank_select_shadow;
    logic [PC_W-1:0]     return_stack_top;
    logic                stack_push;
    logic [15:0]         pmem [256];
    logic [7:0]          dmem [4096];
    int                  fail_count;
    int                  samples_checked;
    int                  n_we;
    int                  n_wdt;
    int                  n_push;

    // ==========================================================
    // clock, memories and pulse counters
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    assign prog_data  = pmem[prog_addr[8:1]];  // small program space, upper bits alias
    assign data_rdata = dmem[data_addr];

    always @(posedge clk) begin
        if (data_we === 1'b1) dmem[data_addr] <= data_wdata;
        if (rst) begin
            n_we   <= 0;
            n_wdt  <= 0;
            n_push <= 0;
        end else begin
            n_we   <= n_we + ((data_we === 1'b1) ? 1 : 0);
            n_wdt  <= n_wdt + ((wdt_clear === 1'b1) ? 1 : 0);
            n_push <= n_push + ((stack_push === 1'b1) ? 1 : 0);
        end
    end

    bcc_core bcc_core_i (
        .clk(clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
        .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we),
        .data_rdata(data_rdata), .ext_iset_en(ext_iset_en), .index_base(index_base),
        .bank_select_ptr(bank_select_ptr), .alu_flag_we(alu_flag_we), .alu_flags(alu_flags),
        .wdt_expired(wdt_expired), .sleep_entered(sleep_entered), .wdt_clear(wdt_clear),
        .watchdog_expiry_flag_n(watchdog_expiry_flag_n), .sleep_flag_n(sleep_flag_n),
        .accumulator(accumulator), .status(status), .accumulator_shadow(accumulator_shadow),
        .flags_shadow(flags_shadow), .bank_select_shadow(bank_select_shadow),
        .return_stack_top(return_stack_top), .stack_push(stack_push)
    );

    // ==========================================================
    // shared helpers
    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic void wipe();
        foreach (pmem[i]) pmem[i] = 16'h0000;
        foreach (dmem[i]) dmem[i] = 8'h5a;
    endfunction : wipe

    // reset on a clock edge, then load the status flags in the first flush cycle
    task automatic boot(input logic [STATUS_W-1:0] f);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst         <= 1'b0;
        alu_flags   <= f;
        alu_flag_we <= 1'b1;
        @(posedge clk);
        alu_flag_we <= 1'b0;
    endtask : boot

    task automatic run(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : run

    // ==========================================================
    // scenarios
    task automatic sc_branch();
        logic [7:0]  op;
        logic [7:0]  n;
        logic [4:0]  f;
        logic        taken;
        logic [20:0] tgt;
        for (int i = 0; i < 4; i++) begin
            op = i[1] ? OP_BR_ZERO : OP_BR_OVF;
            n  = (i == 1 || i == 3) ? 8'h80 : 8'h7f;
            f  = i[0] ? 5'h04 : 5'h08;
            wipe();
            pmem[0] = {op, n};
            boot(f);
            taken = (op == OP_BR_OVF) ? f[SB_OV] : f[SB_Z];
            tgt   = taken ? 21'h2 + {{12{n[7]}}, n, 1'b0} : 21'h4;
            run(7);
            chk("prog_addr", tgt, prog_addr);
            chk("status", f, status);
            run(4);
            chk("prog_addr", tgt + 21'h2, prog_addr);
        end
    endtask : sc_branch

    task automatic sc_call();
        logic [19:0] k;
        k = 20'habc34;
        for (int s = 0; s < 2; s++) begin
            wipe();
            pmem[0] = {OP_CPL_REG, 1'b0, 1'b1, 8'h13};
            pmem[1] = {OP_CALL, s[0], k[7:0]};
            pmem[2] = {CALL2_NIB, k[19:8]};
            dmem[12'h313] = 8'h13;
            bank_select_ptr <= 4'h3;
            boot(5'h01);
            run(7);
            chk("accumulator", 8'hec, accumulator);
            chk("status", 5'h11, status);
            chk("write count", 0, n_we);
            run(4);
            chk("prog_addr", {k, 1'b0}, prog_addr);
            chk("return_stack_top", 21'h6, return_stack_top);
            chk("push count", 1, n_push);
            chk("accumulator_shadow", s ? 8'hec : 8'h00, accumulator_shadow);
            chk("flags_shadow", s ? 5'h11 : 5'h00, flags_shadow);
            chk("bank_select_shadow", s ? 4'h3 : 4'h0, bank_select_shadow);
            run(4);
            chk("prog_addr", {k, 1'b0} + 21'h2, prog_addr);
        end
    endtask : sc_call

    task automatic sc_clear();
        logic        a [5]   = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        logic        ext [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        logic [7:0]  f [5]   = '{8'h20, 8'h5f, 8'h60, 8'h5f, 8'h60};
        logic [11:0] ea [5]  = '{12'h520, 12'h05f, 12'hf60, 12'h000, 12'hf60};
        for (int i = 0; i < 5; i++) begin
            wipe();
            pmem[0] = {OP_CLR_REG, a[i], f[i]};
            bank_select_ptr <= 4'h5;
            ext_iset_en     <= ext[i];
            index_base      <= 12'hfa1;
            boot(5'h1b);
            run(6);
            chk("data_we in q4", 1'b1, data_we);
            run(1);
            chk("data_addr", ea[i], data_addr);
            chk("cleared byte", 8'h00, dmem[ea[i]]);
            chk("status", 5'h1f, status);
            chk("write count", 1, n_we);
        end
    endtask : sc_clear

    task automatic sc_cpl_file();
        wipe();
        pmem[0] = {OP_CPL_REG, 1'b1, 1'b1, 8'h10};
        dmem[12'h010] = 8'hff;
        bank_select_ptr <= 4'h0;
        boot(5'h10);
        run(7);
        chk("complemented byte", 8'h00, dmem[12'h010]);
        chk("status", 5'h04, status);
        chk("accumulator", 8'h00, accumulator);
    endtask : sc_cpl_file

    task automatic sc_watchdog();
        wipe();
        pmem[0] = OP_CLR_WDOG;
        boot(5'h00);
        wdt_expired   <= 1'b1;
        sleep_entered <= 1'b1;
        run(1);
        wdt_expired   <= 1'b0;
        sleep_entered <= 1'b0;
        chk("watchdog_expiry_flag_n", 1'b0, watchdog_expiry_flag_n);
        chk("sleep_flag_n", 1'b0, sleep_flag_n);
        run(6);
        chk("watchdog_expiry_flag_n", 1'b1, watchdog_expiry_flag_n);
        chk("sleep_flag_n", 1'b1, sleep_flag_n);
        chk("wdt_clear count", 1, n_wdt);
    endtask : sc_watchdog

    // ==========================================================
    // verdict, main sequence and hang guard
    task automatic tally_and_finish();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        rst             <= 1'b1;
        alu_flag_we     <= 1'b0;
        alu_flags       <= 5'h00;
        wdt_expired     <= 1'b0;
        sleep_entered   <= 1'b0;
        ext_iset_en     <= 1'b0;
        index_base      <= 12'h000;
        bank_select_ptr <= 4'h0;
        fail_count      = 0;
        samples_checked = 0;
        wipe();
        sc_branch();
        sc_call();
        sc_clear();
        sc_cpl_file();
        sc_watchdog();
        tally_and_finish();
    end

    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule : bcc_core_tb_top
